// *** hdl/flash_launch_defs.vh ***
// Purpose: constants of the flash command launch sequencer
// Assumes: 16-bit register port, word-addressed, one register per address
// Notes:   offsets, field positions, reset values and command codes
// Function
// - any divider write sets the loaded flag; flag low means never written
// - program or erase launched with divider unloaded sets access error, no run
// - while completion flag low, launches and object array writes are ignored
// - index field selects which object array word is read or written
// - writing 1 to completion flag clears it and hands object to controller
// - flag stays low until done; controller sets it, results stay readable
// - code 0x0C accepted only in normal single chip mode
// - codes 0x08 and 0x0B accepted only in special single chip mode
// - 0x0D allowed except secured special; 0x0E only unsecured special
// - secured special accepts only 0x01, 0x02, 0x08 and 0x0B
// - code 0x01 verifies all blocks erased, reports at completion
// - code 0x03 verifies a word range erased; 0x02 verifies a block
// - code 0x07 programs the 64 byte once field; 0x04 reads it back
// - code 0x06 programs one phrase in program flash
// - code 0x08 erases all only with all protect open bits set
// - code 0x09 full program block erase needs both disables and open bit
// - code 0x0a erases the program flash sector holding the address
// - code 0x0b erases all blocks then verifies them to release security
// - high byte of object word 000 is the command code
// - an invalid command code sets access error and is not processed
`ifndef FLASH_LAUNCH_DEFS_VH
`define FLASH_LAUNCH_DEFS_VH

// register addresses
`define ADDR_CLKDIV     3'h0
`define ADDR_CMDIDX     3'h1
`define ADDR_STATUS     3'h2
`define ADDR_PPROT      3'h3
`define ADDR_DPROT      3'h4
`define ADDR_CMDOBJ     3'h5
`define ADDR_MODE       3'h6
`define ADDR_REJECT     3'h7

// field positions
`define CLKDIV_LOADED   7
`define STAT_DONE       7
`define STAT_ACC_ERR    5
`define STAT_PVIOL      4
`define PPROT_OPEN      7
`define PPROT_HDIS      5
`define PPROT_LDIS      4
`define DPROT_OPEN      7
`define MODE_SPECIAL    0
`define MODE_SECURED    1

// reset values
`define RST_DIV         7'h00
`define RST_PPROT       3'h0
`define RST_DPROT       1'h0

// command codes
`define CMD_EV_ALL      8'h01
`define CMD_EV_BLK      8'h02
`define CMD_EV_PSEC     8'h03
`define CMD_RD_ONCE     8'h04
`define CMD_PGM_P       8'h06
`define CMD_PGM_ONCE    8'h07
`define CMD_ERS_ALL     8'h08
`define CMD_ERS_BLK     8'h09
`define CMD_ERS_PSEC    8'h0a
`define CMD_UNSEC       8'h0b
`define CMD_BKDOOR      8'h0c
`define CMD_USR_MRG     8'h0d
`define CMD_FLD_MRG     8'h0e
`define CMD_EV_DSEC     8'h10
`define CMD_PGM_D       8'h11
`define CMD_ERS_DSEC    8'h12

`endif

// *** hdl/flash_launch_seq.v ***
// Purpose: command launch front end of an embedded flash module
// Assumes: controller on core_clk; mode and security pins are asynchronous
// Notes:   words at index 6 and 7 read zero and ignore writes
`timescale 1ns/1ps
`include "flash_launch_defs.vh"
module flash_launch_seq #(
    parameter DIV_W   = 7,
    parameter WORDS   = 6,
    parameter IDX_W   = 3
) (
    // clock and reset
    input  wire               core_clk,
    input  wire               sys_rst,
    // register port
    input  wire [2:0]         reg_addr,
    input  wire [15:0]        reg_wdata,
    input  wire               reg_wr,
    input  wire               reg_rd,
    output reg  [15:0]        reg_rdata_ff,
    // mode pins
    input  wire               special_mode_pin,
    input  wire               secured_pin,
    // controller launch
    output reg                cmd_start_ff,
    output reg  [7:0]         cmd_code_ff,
    output wire [16*WORDS-1:0] cmd_obj_flat,
    output wire               time_base_tick,
    output wire               pflash_full_erase_ok,
    output wire               dflash_full_erase_ok,
    // controller results
    input  wire               ctl_done,
    input  wire               ctl_res_wr,
    input  wire [IDX_W-1:0]   ctl_res_idx,
    input  wire [15:0]        ctl_res_data,
    input  wire               ctl_pviol,
    // status
    output wire               command_complete_flag,
    output wire               access_error_flag
);

// register state
reg  [DIV_W-1:0] div_ff;
reg              div_loaded_ff;
reg  [IDX_W-1:0] idx_ff;
reg              done_ff;
reg              acc_err_ff;
reg              pviol_ff;
reg              pp_open_ff;
reg              pp_hdis_ff;
reg              pp_ldis_ff;
reg              dp_open_ff;
reg  [3:0]       reject_ff;
reg  [15:0]      obj_ff [0:WORDS-1];

// pin synchronisers
reg              spec_s1_ff;
reg              spec_s2_ff;
reg              sec_s1_ff;
reg              sec_s2_ff;

// next values
reg              nxt_done;
reg              nxt_acc_err;
reg              nxt_pviol;
reg  [3:0]       nxt_reject;
reg              nxt_start;
reg  [15:0]      nxt_rdata;

// decode
wire             wr_div;
wire             wr_idx;
wire             wr_stat;
wire             wr_pp;
wire             wr_dp;
wire             wr_obj;
wire             launch_req;
wire [7:0]       code;
wire             known;
wire             allowed;
wire             needs_div;
wire             prot_block;
wire             reject;

integer          i;

// command code is recognised at all
function is_known;
    input [7:0] c;
    begin
        case (c)
            `CMD_EV_ALL, `CMD_EV_BLK, `CMD_EV_PSEC, `CMD_RD_ONCE,
            `CMD_PGM_P, `CMD_PGM_ONCE, `CMD_ERS_ALL, `CMD_ERS_BLK,
            `CMD_ERS_PSEC, `CMD_UNSEC, `CMD_BKDOOR, `CMD_USR_MRG,
            `CMD_FLD_MRG, `CMD_EV_DSEC, `CMD_PGM_D, `CMD_ERS_DSEC:
                is_known = 1'b1;
            default:
                is_known = 1'b0;
        endcase
    end
endfunction

// command permitted in the given mode and security state
function is_allowed;
    input [7:0] c;
    input       spec;
    input       sec;
    begin
        case (c)
            `CMD_EV_ALL, `CMD_EV_BLK:
                is_allowed = 1'b1;
            `CMD_ERS_ALL, `CMD_UNSEC:
                is_allowed = spec;
            `CMD_BKDOOR:
                is_allowed = !spec;
            `CMD_USR_MRG:
                is_allowed = !(spec && sec);
            `CMD_FLD_MRG:
                is_allowed = spec && !sec;
            `CMD_EV_PSEC, `CMD_RD_ONCE, `CMD_PGM_P, `CMD_PGM_ONCE,
            `CMD_ERS_BLK, `CMD_ERS_PSEC, `CMD_EV_DSEC, `CMD_PGM_D,
            `CMD_ERS_DSEC:
                is_allowed = !(spec && sec);
            default:
                is_allowed = 1'b0;
        endcase
    end
endfunction

// command programs or erases cells and so needs the time base
function is_pgm_ers;
    input [7:0] c;
    begin
        case (c)
            `CMD_PGM_P, `CMD_PGM_ONCE, `CMD_ERS_ALL, `CMD_ERS_BLK,
            `CMD_ERS_PSEC, `CMD_UNSEC, `CMD_PGM_D, `CMD_ERS_DSEC:
                is_pgm_ers = 1'b1;
            default:
                is_pgm_ers = 1'b0;
        endcase
    end
endfunction

// two-flop synchronisers for the mode pins
always @(posedge core_clk) begin
    if (sys_rst) begin
        spec_s1_ff <= 1'b0;
        spec_s2_ff <= 1'b0;
        sec_s1_ff  <= 1'b0;
        sec_s2_ff  <= 1'b0;
    end else begin
        spec_s1_ff <= special_mode_pin;
        spec_s2_ff <= spec_s1_ff;
        sec_s1_ff  <= secured_pin;
        sec_s2_ff  <= sec_s1_ff;
    end
end

// address decode
assign wr_div  = reg_wr && (reg_addr == `ADDR_CLKDIV);
assign wr_idx  = reg_wr && (reg_addr == `ADDR_CMDIDX);
assign wr_stat = reg_wr && (reg_addr == `ADDR_STATUS);
assign wr_pp   = reg_wr && (reg_addr == `ADDR_PPROT);
assign wr_dp   = reg_wr && (reg_addr == `ADDR_DPROT);
assign wr_obj  = reg_wr && (reg_addr == `ADDR_CMDOBJ);

// launch only while idle; a write of 1 while busy does nothing
assign launch_req = wr_stat && reg_wdata[`STAT_DONE] && done_ff;

// command code lives in the high byte of word 0
assign code       = obj_ff[0][15:8];
assign known      = is_known(code);
assign allowed    = is_allowed(code, spec_s2_ff, sec_s2_ff);
assign needs_div  = is_pgm_ers(code) && !div_loaded_ff;
// mass erase refused unless every protection is opened
assign prot_block = (code == `CMD_ERS_ALL) &&
                    !(pp_ldis_ff && pp_hdis_ff && pp_open_ff && dp_open_ff);
assign reject     = !known || !allowed || needs_div;

// status flags and launch
always @* begin
    nxt_done    = done_ff;
    nxt_acc_err = acc_err_ff;
    nxt_pviol  = pviol_ff;
    nxt_reject = reject_ff;
    nxt_start  = 1'b0;
    // write one clears the error flags
    if (wr_stat && reg_wdata[`STAT_ACC_ERR]) begin
        nxt_acc_err = 1'b0;
    end
    if (wr_stat && reg_wdata[`STAT_PVIOL]) begin
        nxt_pviol = 1'b0;
    end
    // controller finish; results already sit in the array
    if (!done_ff && ctl_done) begin
        nxt_done = 1'b1;
    end
    if (!done_ff && ctl_pviol) begin
        nxt_pviol = 1'b1;
    end
    if (launch_req) begin
        nxt_reject = {prot_block, needs_div, !allowed, !known};
        if (reject) begin
            nxt_acc_err = 1'b1;
        end else if (prot_block) begin
            nxt_pviol = 1'b1;
        end else begin
            nxt_done  = 1'b0;
            nxt_start = 1'b1;
        end
    end
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        done_ff      <= 1'b1;
        acc_err_ff   <= 1'b0;
        pviol_ff     <= 1'b0;
        reject_ff    <= 4'h0;
        cmd_start_ff <= 1'b0;
        cmd_code_ff  <= 8'h00;
    end else begin
        done_ff      <= nxt_done;
        acc_err_ff   <= nxt_acc_err;
        pviol_ff     <= nxt_pviol;
        reject_ff    <= nxt_reject;
        cmd_start_ff <= nxt_start;
        if (nxt_start) begin
            cmd_code_ff <= code;
        end
    end
end

// clock divider; the loaded flag only falls at reset
always @(posedge core_clk) begin
    if (sys_rst) begin
        div_ff        <= `RST_DIV;
        div_loaded_ff <= 1'b0;
    end else if (wr_div) begin
        div_ff        <= reg_wdata[DIV_W-1:0];
        div_loaded_ff <= 1'b1;
    end
end

// index and protection registers
always @(posedge core_clk) begin
    if (sys_rst) begin
        idx_ff     <= {IDX_W{1'b0}};
        pp_open_ff <= 1'b0;
        pp_hdis_ff <= 1'b0;
        pp_ldis_ff <= 1'b0;
        dp_open_ff <= `RST_DPROT;
    end else begin
        if (wr_idx) begin
            idx_ff <= reg_wdata[IDX_W-1:0];
        end
        if (wr_pp) begin
            pp_open_ff <= reg_wdata[`PPROT_OPEN];
            pp_hdis_ff <= reg_wdata[`PPROT_HDIS];
            pp_ldis_ff <= reg_wdata[`PPROT_LDIS];
        end
        if (wr_dp) begin
            dp_open_ff <= reg_wdata[`DPROT_OPEN];
        end
    end
end

// object array: software writes while idle, controller returns results while busy
always @(posedge core_clk) begin
    if (sys_rst) begin
        for (i = 0; i < WORDS; i = i + 1) begin
            obj_ff[i] <= 16'h0000;
        end
    end else if (done_ff) begin
        if (wr_obj && (idx_ff < WORDS)) begin
            obj_ff[idx_ff] <= reg_wdata;
        end
    end else if (ctl_res_wr && (ctl_res_idx < WORDS)) begin
        obj_ff[ctl_res_idx] <= ctl_res_data;
    end
end

// only controller result writes change the array while busy, so the controller reads it directly
genvar g;
generate
    for (g = 0; g < WORDS; g = g + 1) begin : obj_out
        assign cmd_obj_flat[16*g +: 16] = obj_ff[g];
    end
endgenerate

// read data, one cycle after the strobe
always @* begin
    nxt_rdata = 16'h0000;
    if (reg_addr == `ADDR_CLKDIV) begin
        nxt_rdata[DIV_W-1:0]      = div_ff;
        nxt_rdata[`CLKDIV_LOADED] = div_loaded_ff;
    end else if (reg_addr == `ADDR_CMDIDX) begin
        nxt_rdata[IDX_W-1:0] = idx_ff;
    end else if (reg_addr == `ADDR_STATUS) begin
        nxt_rdata[`STAT_DONE]    = done_ff;
        nxt_rdata[`STAT_ACC_ERR] = acc_err_ff;
        nxt_rdata[`STAT_PVIOL]  = pviol_ff;
    end else if (reg_addr == `ADDR_PPROT) begin
        nxt_rdata[`PPROT_OPEN] = pp_open_ff;
        nxt_rdata[`PPROT_HDIS] = pp_hdis_ff;
        nxt_rdata[`PPROT_LDIS] = pp_ldis_ff;
    end else if (reg_addr == `ADDR_DPROT) begin
        nxt_rdata[`DPROT_OPEN] = dp_open_ff;
    end else if (reg_addr == `ADDR_CMDOBJ) begin
        if (idx_ff < WORDS) begin
            nxt_rdata = obj_ff[idx_ff];
        end
    end else if (reg_addr == `ADDR_MODE) begin
        nxt_rdata[`MODE_SPECIAL] = spec_s2_ff;
        nxt_rdata[`MODE_SECURED] = sec_s2_ff;
    end else begin
        nxt_rdata[3:0] = reject_ff;
    end
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        reg_rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
        reg_rdata_ff <= nxt_rdata;
    end else begin
        reg_rdata_ff <= 16'h0000;
    end
end

// full-block erase permissions for the controller
assign pflash_full_erase_ok = pp_ldis_ff && pp_hdis_ff && pp_open_ff;
assign dflash_full_erase_ok = dp_open_ff;

assign command_complete_flag = done_ff;
assign access_error_flag     = acc_err_ff;

// time base runs only once software has loaded the divider
flash_time_base #(
    .DIV_W   (DIV_W)
) u_time_base (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .enable   (div_loaded_ff),
    .div_val  (div_ff),
    .tick_ff  (time_base_tick)
);

endmodule

// *** hdl/flash_time_base.v ***
// Purpose: divides the bus clock into the flash time base tick
// Assumes: divider_value_field stable while a command runs
// Notes:   tick period is div_val + 1 bus clocks
`timescale 1ns/1ps
module flash_time_base #(
    parameter DIV_W = 7
) (
    // clock and reset
    input  wire             core_clk,
    input  wire             sys_rst,
    // control
    input  wire             enable,
    input  wire [DIV_W-1:0] div_val,
    // time base
    output reg              tick_ff
);

reg  [DIV_W-1:0] cnt_ff;
wire             wrap;

assign wrap = (cnt_ff >= div_val);

always @(posedge core_clk) begin
    if (sys_rst || !enable) begin
        cnt_ff  <= {DIV_W{1'b0}};
        tick_ff <= 1'b0;
    end else begin
        // restart counting once the count reaches the divider value
        cnt_ff  <= wrap ? {DIV_W{1'b0}} : cnt_ff + 1'b1;
        tick_ff <= wrap;
    end
end

endmodule

// *** sim/flash_launch_seq_sva.sv ***
// Purpose: concurrent checks on the launch sequencer ports
// Assumes: launches made with index 0; pins held for 4 clocks before a launch
// Notes:   mode checks only fire once both pin histories are steady
`timescale 1ns/1ps
`include "flash_launch_defs.vh"
module flash_launch_seq_sva #(
    parameter DIV_W = 7,
    parameter WORDS = 6,
    parameter IDX_W = 3
) (
    // clock and reset
    input wire                core_clk,
    input wire                sys_rst,
    // register port
    input wire [2:0]          reg_addr,
    input wire [15:0]         reg_wdata,
    input wire                reg_wr,
    input wire                reg_rd,
    input wire [15:0]         reg_rdata_ff,
    // mode pins
    input wire                special_mode_pin,
    input wire                secured_pin,
    // controller side
    input wire                cmd_start_ff,
    input wire [7:0]          cmd_code_ff,
    input wire [16*WORDS-1:0] cmd_obj_flat,
    input wire                time_base_tick,
    input wire                pflash_full_erase_ok,
    input wire                dflash_full_erase_ok,
    input wire                ctl_done,
    input wire                ctl_res_wr,
    input wire [IDX_W-1:0]    ctl_res_idx,
    input wire [15:0]         ctl_res_data,
    input wire                ctl_pviol,
    // status
    input wire                command_complete_flag,
    input wire                access_error_flag
);
    reg  [3:0] spec_hist_ff;
    reg  [3:0] sec_hist_ff;
    reg        div_seen_ff;
    wire [7:0] obj_code = cmd_obj_flat[15:8];
    // pins pass a two-stage synchroniser, so only trust steady history
    wire mode_ok = (spec_hist_ff == {4{special_mode_pin}}) && (sec_hist_ff == {4{secured_pin}});

    function cmd_ok(input [7:0] c, input sp, input sc);
        case (c)
            8'h01, 8'h02: cmd_ok = 1'b1;
            8'h08, 8'h0b: cmd_ok = sp;
            8'h0c: cmd_ok = !sp;
            8'h0e: cmd_ok = sp && !sc;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12: cmd_ok = !(sp && sc);
            default: cmd_ok = 1'b0;
        endcase
    endfunction

    wire needs_div = obj_code inside {8'h06, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h11, 8'h12};
    wire bad_launch = !cmd_ok(obj_code, special_mode_pin, secured_pin) || (needs_div && !div_seen_ff);
    wire mass_block = (obj_code == 8'h08) && !(pflash_full_erase_ok && dflash_full_erase_ok);

    always @(posedge core_clk) begin
        spec_hist_ff <= {spec_hist_ff[2:0], special_mode_pin};
        sec_hist_ff <= {sec_hist_ff[2:0], secured_pin};
        if (sys_rst)
            div_seen_ff <= 1'b0;
        else if (reg_wr && reg_addr == `ADDR_CLKDIV)
            div_seen_ff <= 1'b1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence launch_req;
        reg_wr && reg_addr == `ADDR_STATUS && reg_wdata[`STAT_DONE] && command_complete_flag && mode_ok;
    endsequence
    sequence start_now;
        cmd_start_ff && !command_complete_flag;
    endsequence

    AST_LAUNCH_OK: assert property (launch_req and (!bad_launch && !mass_block) |=> start_now)
        else $error("valid launch did not start");
    AST_LAUNCH_BAD: assert property (launch_req and bad_launch |=> access_error_flag && command_complete_flag && !cmd_start_ff)
        else $error("refused launch not flagged");
    AST_MASS_BLOCK: assert property (launch_req and (!bad_launch && mass_block) |=> !cmd_start_ff && command_complete_flag)
        else $error("mass erase started while protected");
    AST_START_CAUSE: assert property (cmd_start_ff |-> $past(command_complete_flag) && $past(reg_wr) && $past(reg_addr) == `ADDR_STATUS)
        else $error("start without idle launch write");
    AST_START_PULSE: assert property (cmd_start_ff |=> !cmd_start_ff)
        else $error("start longer than one cycle");
    AST_CODE: assert property (cmd_start_ff |-> cmd_code_ff == obj_code)
        else $error("code not from word zero high byte");
    AST_BUSY_HOLD: assert property (!command_complete_flag && !ctl_done |=> !command_complete_flag)
        else $error("completion rose without done");
    AST_DONE: assert property (!command_complete_flag && ctl_done |=> command_complete_flag)
        else $error("done did not set completion");
    AST_FROZEN: assert property (!command_complete_flag && !ctl_res_wr |=> $stable(cmd_obj_flat))
        else $error("object changed while busy");
    AST_TICK_OFF: assert property (!div_seen_ff |-> !time_base_tick)
        else $error("tick without divider loaded");
endmodule

// *** sim/tb.sv ***
// Purpose: self-checking bench for the flash command launch sequencer
// Assumes: index 0 at each launch; pins steady for several clocks before
// Notes:   sweeps every command code through all four mode states
`timescale 1ns/1ps
`include "flash_launch_defs.vh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb;
    reg         core_clk = 1'b0;
    reg         sys_rst = 1'b1;
    reg  [2:0]  reg_addr = 3'h0;
    reg  [15:0] reg_wdata = 16'h0000;
    reg         reg_wr = 1'b0;
    reg         reg_rd = 1'b0;
    reg         special_mode_pin = 1'b0;
    reg         secured_pin = 1'b0;
    reg         ctl_done = 1'b0;
    reg         ctl_res_wr = 1'b0;
    reg  [2:0]  ctl_res_idx = 3'h0;
    reg  [15:0] ctl_res_data = 16'h0000;
    reg         ctl_pviol = 1'b0;
    wire [15:0] reg_rdata_ff;
    wire        cmd_start_ff;
    wire [7:0]  cmd_code_ff;
    wire [95:0] cmd_obj_flat;
    wire        time_base_tick;
    wire        pflash_full_erase_ok;
    wire        dflash_full_erase_ok;
    wire        command_complete_flag;
    wire        access_error_flag;
    integer     err_total = 0;
    integer     comparisons = 0;
    integer     starts = 0;
    integer     ticks = 0;
    integer     seed = 32'h3cda;
    integer     s0, i, m, rnd;
    reg  [15:0] rd_v, r;
    reg  [7:0]  code;
    // two unknown codes at the tail
    reg  [143:0] code_list = {8'hff, 8'h05, 8'h12, 8'h11, 8'h10, 8'h0e, 8'h0d, 8'h0c, 8'h0b,
                              8'h0a, 8'h09, 8'h08, 8'h07, 8'h06, 8'h04, 8'h03, 8'h02, 8'h01};

    flash_launch_seq i_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .special_mode_pin(special_mode_pin), .secured_pin(secured_pin),
        .cmd_start_ff(cmd_start_ff), .cmd_code_ff(cmd_code_ff), .cmd_obj_flat(cmd_obj_flat),
        .time_base_tick(time_base_tick), .pflash_full_erase_ok(pflash_full_erase_ok),
        .dflash_full_erase_ok(dflash_full_erase_ok), .ctl_done(ctl_done), .ctl_res_wr(ctl_res_wr),
        .ctl_res_idx(ctl_res_idx), .ctl_res_data(ctl_res_data), .ctl_pviol(ctl_pviol),
        .command_complete_flag(command_complete_flag), .access_error_flag(access_error_flag));

    always #4 core_clk = ~core_clk;
    always @(posedge core_clk) if (cmd_start_ff === 1'b1) starts <= starts + 1;
    always @(posedge core_clk) if (time_base_tick === 1'b1) ticks <= ticks + 1;

    function exp_ok(input [7:0] c, input sp, input sc);
        case (c)
            8'h01, 8'h02: exp_ok = 1'b1;
            8'h08, 8'h0b: exp_ok = sp;
            8'h0c: exp_ok = !sp;
            8'h0e: exp_ok = sp && !sc;
            8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12: exp_ok = !(sp && sc);
            default: exp_ok = 1'b0;
        endcase
    endfunction

    task wr(input [2:0] a, input [15:0] d);
        begin
            @(posedge core_clk);
            reg_wr <= 1'b1;
            reg_addr <= a;
            reg_wdata <= d;
            @(posedge core_clk);
            reg_wr <= 1'b0;
        end
    endtask

    task chk_rd(input [2:0] a, input [15:0] e);
        begin
            @(posedge core_clk);
            reg_rd <= 1'b1;
            reg_addr <= a;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            #1;
            rd_v = reg_rdata_ff;
            `CHK(rd_v, e)
        end
    endtask

    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_total);
            if (err_total == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask

    initial begin
        repeat (100000) @(posedge core_clk);
        err_total = err_total + 1;
        final_report;
    end

    initial begin
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_rd(`ADDR_CLKDIV, 16'h0000);
        chk_rd(`ADDR_STATUS, 16'h0080);
        // program code before the divider was ever written
        wr(`ADDR_CMDOBJ, 16'h0600);
        s0 = starts;
        wr(`ADDR_STATUS, 16'h0080);
        chk_rd(`ADDR_STATUS, 16'h00a0);
        `CHK(starts, s0)
        wr(`ADDR_STATUS, 16'h0030);
        rnd = $random(seed);
        wr(`ADDR_CLKDIV, {9'h000, rnd[6:0]});
        chk_rd(`ADDR_CLKDIV, {8'h00, 1'b1, rnd[6:0]});
        // a strictly periodic tick gives exactly 4 in 4 periods
        s0 = ticks;
        repeat (4 * (rnd[6:0] + 1)) @(posedge core_clk);
        #1;
        `CHK(ticks - s0, 4)
        for (i = 0; i < 8; i = i + 1) begin
            wr(`ADDR_CMDIDX, i[15:0]);
            wr(`ADDR_CMDOBJ, 16'h1111 * i[15:0] + 16'h0101);
        end
        for (i = 7; i >= 0; i = i - 1) begin
            wr(`ADDR_CMDIDX, i[15:0]);
            chk_rd(`ADDR_CMDOBJ, (i < 6) ? 16'h1111 * i[15:0] + 16'h0101 : 16'h0000);
        end
        // mass erase in special mode with protection still closed
        @(posedge core_clk);
        special_mode_pin <= 1'b1;
        wr(`ADDR_PPROT, 16'h0030);
        wr(`ADDR_CMDIDX, 16'h0000);
        wr(`ADDR_CMDOBJ, 16'h0800);
        s0 = starts;
        wr(`ADDR_STATUS, 16'h0080);
        chk_rd(`ADDR_STATUS, 16'h0090);
        `CHK(starts, s0)
        wr(`ADDR_STATUS, 16'h0030);
        wr(`ADDR_PPROT, 16'h00b0);
        wr(`ADDR_DPROT, 16'h0080);
        #1;
        `CHK(pflash_full_erase_ok, 1'b1)
        `CHK(dflash_full_erase_ok, 1'b1)
        for (m = 0; m < 4; m = m + 1) begin
            @(posedge core_clk);
            special_mode_pin <= m[0];
            secured_pin <= m[1];
            for (i = 0; i < 18; i = i + 1) begin
                code = code_list[8*i +: 8];
                wr(`ADDR_CMDIDX, 16'h0000);
                wr(`ADDR_CMDOBJ, {code, 8'h00});
                s0 = starts;
                wr(`ADDR_STATUS, 16'h0080);
                @(posedge core_clk);
                #1;
                if (exp_ok(code, m[0], m[1])) begin
                    `CHK(starts, s0 + 1)
                    `CHK(cmd_code_ff, code)
                    `CHK(cmd_obj_flat[15:0], {code, 8'h00})
                    rnd = $random(seed);
                    r = rnd[15:0];
                    // both of these land while busy and must be dropped
                    wr(`ADDR_CMDOBJ, r);
                    wr(`ADDR_STATUS, 16'h0080);
                    `CHK(command_complete_flag, 1'b0)
                    @(posedge core_clk);
                    ctl_res_wr <= 1'b1;
                    ctl_res_idx <= 3'h1;
                    ctl_res_data <= r ^ 16'h5a5a;
                    @(posedge core_clk);
                    ctl_res_wr <= 1'b0;
                    ctl_done <= 1'b1;
                    ctl_pviol <= m[0];
                    @(posedge core_clk);
                    ctl_done <= 1'b0;
                    ctl_pviol <= 1'b0;
                    `CHK(starts, s0 + 1)
                    chk_rd(`ADDR_STATUS, {8'h00, 1'b1, 2'b00, m[0], 4'h0});
                    chk_rd(`ADDR_CMDOBJ, {code, 8'h00});
                    wr(`ADDR_CMDIDX, 16'h0001);
                    chk_rd(`ADDR_CMDOBJ, r ^ 16'h5a5a);
                end else begin
                    `CHK(starts, s0)
                    `CHK(access_error_flag, 1'b1)
                    chk_rd(`ADDR_STATUS, 16'h00a0);
                    chk_rd(`ADDR_REJECT,
                           {14'h0000, !exp_ok(code, m[0], m[1]), (code == 8'h05 || code == 8'hff)});
                end
                wr(`ADDR_STATUS, 16'h0030);
            end
            chk_rd(`ADDR_MODE, {14'h0000, m[1], m[0]});
        end
        // second reset in mid-run: divider must read unloaded again
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        chk_rd(`ADDR_CLKDIV, 16'h0000);
        chk_rd(`ADDR_STATUS, 16'h0080);
        chk_rd(`ADDR_CMDOBJ, 16'h0000);
        final_report;
    end
endmodule

bind flash_launch_seq flash_launch_seq_sva #(.DIV_W(DIV_W), .WORDS(WORDS), .IDX_W(IDX_W)) u_sva (
    .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .special_mode_pin(special_mode_pin), .secured_pin(secured_pin),
    .cmd_start_ff(cmd_start_ff), .cmd_code_ff(cmd_code_ff), .cmd_obj_flat(cmd_obj_flat),
    .time_base_tick(time_base_tick), .pflash_full_erase_ok(pflash_full_erase_ok),
    .dflash_full_erase_ok(dflash_full_erase_ok), .ctl_done(ctl_done), .ctl_res_wr(ctl_res_wr),
    .ctl_res_idx(ctl_res_idx), .ctl_res_data(ctl_res_data), .ctl_pviol(ctl_pviol),
    .command_complete_flag(command_complete_flag), .access_error_flag(access_error_flag));
